// ### core/scd_decoder.sv
// strap decoder with mode s reply gating and status registers
//
// The address map and strobed register access were decided locally.
`include "scd_params.svh"
module scd_decoder
  import scd_pkg::*;
#(
  parameter int REFRESH_CYC = `SCD_REFRESH_CYC
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic TYPE_SET_N,
  input wire logic CAT_LO_N,
  input wire logic CAT_MID_N,
  input wire logic CAT_HI_N,
  input wire logic CONFIG_STRAP_LO_N,
  input wire logic CONFIG_STRAP_HI_N,
  input wire logic AIR_GND1_N,
  input wire logic AIR_GND2_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic MS_REQ,
  input wire logic [7:0] MS_BDS,
  output logic REPLY_VALID,
  output logic [4:0] REPLY_DF,
  output logic [55:0] REPLY_MB,
  output logic [2:0] CATEGORY,
  output logic TYPE_SET_B,
  output logic [1:0] CONFIG_SEL,
  output logic CONFIG_ILLEGAL,
  output logic AIRBORNE,
  output logic [31:0] LBL353_WORD
);

  localparam scd_age_t REFRESH = scd_age_t'(REFRESH_CYC);

  // configuration code 3 is the one illegal selection
  function automatic logic cfg_bad(input logic [1:0] cfg);
    return cfg == `SCD_CFG_ILLEGAL;
  endfunction

  // filtered straps, bit order: ag2 ag1 cfg_hi cfg_lo cat_hi cat_mid cat_lo set
  logic [7:0] act;

  scd_strap_filt #(.W(8)) u_filt (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .pins_n({AIR_GND2_N, AIR_GND1_N, CONFIG_STRAP_HI_N, CONFIG_STRAP_LO_N,
             CAT_HI_N, CAT_MID_N, CAT_LO_N, TYPE_SET_N}),
    .active(act)
  );

  // ---------------- strap decode ----------------
  logic [2:0] cat_q, cat_d;
  logic set_b_q, set_b_d;
  logic [1:0] cfg_q, cfg_d;
  logic ill_q, ill_d;
  logic air_q, air_d;
  logic [31:0] lbl_q, lbl_d;

  // category is the binary weight of the straps; the set strap picks the table
  always_comb begin
    set_b_d = act[0];
    cat_d = {act[3], act[2], act[1]};
    cfg_d = {act[5], act[4]};
    ill_d = cfg_bad(cfg_d);
    air_d = ~(act[6] | act[7]);
    lbl_d = 32'h0;
    lbl_d[7:0] = `SCD_LBL353_LABEL;
    lbl_d[`SCD_LBL353_ILL_BIT] = ill_d;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cat_q <= 3'h0;
      set_b_q <= 1'b0;
      cfg_q <= 2'h0;
      ill_q <= 1'b0;
      air_q <= 1'b1;
      lbl_q <= {24'h0, `SCD_LBL353_LABEL};
    end else begin
      cat_q <= cat_d;
      set_b_q <= set_b_d;
      cfg_q <= cfg_d;
      ill_q <= ill_d;
      air_q <= air_d;
      lbl_q <= lbl_d;
    end
  end

  assign CATEGORY = cat_q;
  assign TYPE_SET_B = set_b_q;
  assign CONFIG_SEL = cfg_q;
  assign CONFIG_ILLEGAL = ill_q;
  assign AIRBORNE = air_q;
  assign LBL353_WORD = lbl_q;

  // ---------------- software registers ----------------
  logic [1:0] ctrl_q, ctrl_d;
  logic [47:0] ident_q, ident_d;
  scd_mb_t ads_q, ads_d;
  scd_age_t age_q, age_d;
  logic stale;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;

  // writing the upper primary word marks the whole set as refreshed
  always_comb begin
    ctrl_d = ctrl_q;
    ident_d = ident_q;
    ads_d = ads_q;
    age_d = age_q;
    if (age_q < REFRESH) begin
      age_d = age_q + scd_age_t'(1);
    end
    if (WR) begin
      unique case (ADDR)
        `SCD_OFS_CTRL: ctrl_d = WDATA[1:0];
        `SCD_OFS_IDENT_LO: ident_d[31:0] = WDATA;
        `SCD_OFS_IDENT_HI: ident_d[47:32] = WDATA[15:0];
        `SCD_OFS_ADS_LO: ads_d[31:0] = WDATA;
        `SCD_OFS_ADS_HI: begin
          ads_d[55:32] = WDATA[23:0];
          age_d = '0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= `SCD_CTRL_RST;
      ident_q <= 48'h0;
      ads_q <= 56'h0;
      age_q <= `SCD_AGE_MAX;
    end else begin
      ctrl_q <= ctrl_d;
      ident_q <= ident_d;
      ads_q <= ads_d;
      age_q <= age_d;
    end
  end

  // data older than the refresh limit is treated as absent
  assign stale = age_q >= REFRESH;

  always_comb begin
    status = 32'h0;
    status[`SCD_ST_CAT +: 3] = cat_q;
    status[`SCD_ST_SETB] = set_b_q;
    status[`SCD_ST_CFG +: 2] = cfg_q;
    status[`SCD_ST_ILL] = ill_q;
    status[`SCD_ST_AIR] = air_q;
    status[`SCD_ST_STALE] = stale;
  end

  // read data appear only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 32'h0;
    if (RD) begin
      unique case (ADDR)
        `SCD_OFS_CTRL: rdata_d = {30'h0, ctrl_q};
        `SCD_OFS_STATUS: rdata_d = status;
        `SCD_OFS_IDENT_LO: rdata_d = ident_q[31:0];
        `SCD_OFS_IDENT_HI: rdata_d = {16'h0, ident_q[47:32]};
        `SCD_OFS_ADS_LO: rdata_d = ads_q[31:0];
        `SCD_OFS_ADS_HI: rdata_d = {8'h0, ads_q[55:32]};
        `SCD_OFS_LBL353: rdata_d = lbl_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // ---------------- mode s reply sequencer ----------------
  scd_reply_e st_q, st_d;
  logic is08_q, is08_d;
  logic vld_q, vld_d;
  logic [4:0] df_q, df_d;
  scd_mb_t mb_q, mb_d;
  logic take08, take05;

  // requests for disabled or unknown registers draw no reply
  assign take08 = MS_REQ && MS_BDS == `SCD_BDS_08 && ctrl_q[`SCD_CTRL_EN08];
  assign take05 = MS_REQ && MS_BDS == `SCD_BDS_05 && ctrl_q[`SCD_CTRL_EN05];

  // the mb field is latched from the decoded straps one cycle after the
  // request, so a strap change mid-request cannot tear the reply
  always_comb begin
    st_d = st_q;
    is08_d = is08_q;
    vld_d = 1'b0;
    df_d = df_q;
    mb_d = mb_q;
    unique case (st_q)
      SCD_IDLE: begin
        if (take08 || take05) begin
          is08_d = take08;
          st_d = SCD_BUILD;
        end
      end
      SCD_BUILD: begin
        df_d = `SCD_DF20;
        if (is08_q) begin
          mb_d = {set_b_q ? `SCD_TC_SET_B : `SCD_TC_SET_A, cat_q, ident_q};
        end else begin
          mb_d = stale ? 56'h0 : ads_q;
        end
        vld_d = 1'b1;
        st_d = SCD_SEND;
      end
      SCD_SEND: begin
        st_d = SCD_IDLE;
      end
      default: begin
        st_d = SCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= SCD_IDLE;
      is08_q <= 1'b0;
      vld_q <= 1'b0;
      df_q <= 5'h0;
      mb_q <= 56'h0;
    end else begin
      st_q <= st_d;
      is08_q <= is08_d;
      vld_q <= vld_d;
      df_q <= df_d;
      mb_q <= mb_d;
    end
  end

  assign REPLY_VALID = vld_q;
  assign REPLY_DF = df_q;
  assign REPLY_MB = mb_q;

endmodule

// ### common/scd_params.svh
// constants for the strap configuration decoder
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// register byte offsets
`define SCD_OFS_CTRL 8'h00
`define SCD_OFS_STATUS 8'h04
`define SCD_OFS_IDENT_LO 8'h08
`define SCD_OFS_IDENT_HI 8'h0c
`define SCD_OFS_ADS_LO 8'h10
`define SCD_OFS_ADS_HI 8'h14
`define SCD_OFS_LBL353 8'h18

// control fields and reset value
`define SCD_CTRL_EN08 0
`define SCD_CTRL_EN05 1
`define SCD_CTRL_RST 2'h3

// status field positions
`define SCD_ST_CAT 0
`define SCD_ST_SETB 3
`define SCD_ST_CFG 4
`define SCD_ST_ILL 6
`define SCD_ST_AIR 7
`define SCD_ST_STALE 8

// output word label 353 (octal) and its illegal-configuration bit 13
`define SCD_LBL353_LABEL 8'heb
`define SCD_LBL353_ILL_BIT 13

// mode s reply format and surveillance register numbers
`define SCD_DF20 5'h14
`define SCD_BDS_08 8'h08
`define SCD_BDS_05 8'h05

// type codes placed ahead of the category in the 0,8 reply
`define SCD_TC_SET_A 5'h04
`define SCD_TC_SET_B 5'h03

// illegal configuration code
`define SCD_CFG_ILLEGAL 2'h3

// strap filter time and clock rate
`define SCD_CLK_MHZ 200
`define SCD_DEB_NS 1000
`define SCD_DEB_CYC ((`SCD_DEB_NS * `SCD_CLK_MHZ + 999) / 1000)

// primary data refresh limit: 1 s
`define SCD_REFRESH_MS 1000
`define SCD_REFRESH_CYC (`SCD_REFRESH_MS * `SCD_CLK_MHZ * 1000)
`define SCD_AGE_MAX 28'hfffffff

`endif

// ### common/scd_pkg.sv
// types for the strap configuration decoder
package scd_pkg;

  // reply sequencer, gray coded along idle -> build -> send
  typedef enum logic [1:0] {
    SCD_IDLE = 2'b00,
    SCD_BUILD = 2'b01,
    SCD_SEND = 2'b11
  } scd_reply_e;

  typedef logic [55:0] scd_mb_t;
  typedef logic [27:0] scd_age_t;

endpackage

// ### core/scd_strap_filt.sv
// two-flop synchroniser and stability filter for ground/open straps
`include "scd_params.svh"
module scd_strap_filt #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pins_n,
  output logic [W-1:0] active
);

  localparam int CW = 8;
  localparam logic [CW-1:0] DEB = CW'(`SCD_DEB_CYC);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, act_q, act_d;
      logic [CW-1:0] cnt_q, cnt_d;

      // a grounded pin reads low, so the filtered level is inverted
      always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (~s2_q == act_q) begin
          cnt_d = '0;
        end else if (cnt_q == DEB - CW'(1)) begin
          act_d = ~s2_q;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end

      // s1 is read only by s2; pins start as open
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          act_q <= 1'b0;
          cnt_q <= '0;
        end else begin
          s1_q <= pins_n[i];
          s2_q <= s1_q;
          act_q <= act_d;
          cnt_q <= cnt_d;
        end
      end

      assign active[i] = act_q;
    end
  endgenerate

endmodule

// ### test/scd_straps.sv
// model of the aircraft wiring: each strap is either grounded or left open
module scd_straps (
  input wire logic [7:0] gnd,
  output logic [7:0] pins_n
);
  // open straps float up through the pull-ups, grounded ones pull low
  assign pins_n = ~gnd;
endmodule

// ### test/scd_decoder_sva.sv
// port assertions for the strap configuration decoder
module scd_decoder_sva (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic MS_REQ,
  input wire logic [7:0] MS_BDS,
  input wire logic REPLY_VALID,
  input wire logic [4:0] REPLY_DF,
  input wire logic [55:0] REPLY_MB,
  input wire logic [2:0] CATEGORY,
  input wire logic TYPE_SET_B,
  input wire logic [1:0] CONFIG_SEL,
  input wire logic CONFIG_ILLEGAL,
  input wire logic [31:0] LBL353_WORD
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // replies follow their request by two cycles and last one
  reply_lat_a:
    assert property (REPLY_VALID |-> $past(MS_REQ, 2)) else $error("reply without request");
  reply_pulse_a:
    assert property (REPLY_VALID |=> !REPLY_VALID) else $error("reply too long");
  reply_df_a:
    assert property (REPLY_VALID |-> REPLY_DF == 5'h14) else $error("reply format wrong");
  mb_ident_a:
    assert property (REPLY_VALID && $past(MS_BDS, 2) == 8'h08 |->
      REPLY_MB[55:48] == {TYPE_SET_B ? 5'h03 : 5'h04, CATEGORY}) else $error("bad mb head");
  // the illegal flag and the output word bit follow configuration 3
  illegal_cfg_a:
    assert property (CONFIG_ILLEGAL == (CONFIG_SEL == 2'h3)) else $error("illegal flag wrong");
  label_bit_a:
    assert property (CONFIG_ILLEGAL [*3] |-> LBL353_WORD[13]) else $error("label bit low");
  label_code_a:
    assert property (LBL353_WORD[7:0] == 8'heb) else $error("label code wrong");
  rdata_idle_a:
    assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data not idle");
  cover property (REPLY_VALID && REPLY_MB == 56'h0);
  cover property (REPLY_VALID && TYPE_SET_B);
  cover property ($rose(CONFIG_ILLEGAL));
endmodule

bind scd_decoder scd_decoder_sva scd_decoder_sva_inst (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .RD(RD), .RDATA(RDATA), .MS_REQ(MS_REQ), .MS_BDS(MS_BDS), .REPLY_VALID(REPLY_VALID),
  .REPLY_DF(REPLY_DF), .REPLY_MB(REPLY_MB), .CATEGORY(CATEGORY), .TYPE_SET_B(TYPE_SET_B),
  .CONFIG_SEL(CONFIG_SEL), .CONFIG_ILLEGAL(CONFIG_ILLEGAL), .LBL353_WORD(LBL353_WORD));

// ### test/scd_decoder_tb.sv
// self-checking bench for the strap configuration decoder
`include "scd_params.svh"
module scd_decoder_tb
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, rd_q = 1'b0;
  // no initial value: a declared value raises no edge, so the async reset would never fire
  logic arst_n;
  logic rv, tsb, ill, air;
  logic [7:0] gnd = 8'h00, pins, addr = 8'h00, bds = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, lbl, lfsr_q = 32'h5cc06402;
  logic [4:0] df;
  logic [2:0] cat;
  logic [1:0] cfg;
  scd_mb_t mb, ident, ads;
  scd_mb_t exp_mb[$];
  logic [31:0] exp_rd[$];
  // strap sets: bit 7 type set, 6..4 category, 3..2 config, 1..0 air/ground
  logic [7:0] tbl[4] = '{8'ha2, 8'h59, 8'h0f, 8'h00};
  int n_mismatch = 0, comparisons = 0;

  initial forever #2.5 clk = ~clk;
  scd_straps scd_straps_inst (.gnd(gnd), .pins_n(pins));
  // short refresh limit so the stale case fits in the run
  scd_decoder #(.REFRESH_CYC(50)) scd_decoder_inst (.CLK_SYS(clk), .ARST_N(arst_n),
    .TYPE_SET_N(pins[7]), .CAT_HI_N(pins[6]), .CAT_MID_N(pins[5]), .CAT_LO_N(pins[4]),
    .CONFIG_STRAP_HI_N(pins[3]), .CONFIG_STRAP_LO_N(pins[2]), .AIR_GND1_N(pins[1]),
    .AIR_GND2_N(pins[0]), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MS_REQ(req), .MS_BDS(bds), .REPLY_VALID(rv), .REPLY_DF(df), .REPLY_MB(mb),
    .CATEGORY(cat), .TYPE_SET_B(tsb), .CONFIG_SEL(cfg), .CONFIG_ILLEGAL(ill),
    .AIRBORNE(air), .LBL353_WORD(lbl));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic rnd(output scd_mb_t v);
    lfsr_q = lfsr(lfsr_q);
    v[31:0] = lfsr_q;
    lfsr_q = lfsr(lfsr_q);
    v[55:32] = lfsr_q[23:0];
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // request held n cycles; with n of 2 the second cycle lands while busy and must be refused
  task automatic ask(input logic [7:0] b, input int n, input logic take, input scd_mb_t e);
    @(posedge clk);
    req <= 1'b1;
    bds <= b;
    if (take) exp_mb.push_back(e);
    cyc(n);
    req <= 1'b0;
    cyc(3);
  endtask
  task automatic strap(input logic [7:0] g);
    logic [1:0] c;
    c = g[3:2];
    @(posedge clk);
    gnd <= g;
    cyc(210);
    chk("category", g[6:4], cat);
    chk("type set", g[7], tsb);
    chk("config", c, cfg);
    chk("illegal", &c, ill);
    chk("label bit", &c, lbl[13]);
    chk("airborne", ~|g[1:0], air);
    rreg(`SCD_OFS_STATUS, {23'h0, 1'b1, ~|g[1:0], &c, c, g[7], g[6:4]});
    rreg(`SCD_OFS_LBL353, {18'h0, &c, 5'h0, `SCD_LBL353_LABEL});
    ask(`SCD_BDS_08, 2, 1'b1, {g[7] ? `SCD_TC_SET_B : `SCD_TC_SET_A, g[6:4], ident[47:0]});
  endtask

  // results are matched against the oldest expectation as they appear
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) chk("rdata", exp_rd.size() ? exp_rd.pop_front() : 'x, rdata);
    if (rv === 1'b1) begin
      chk("reply df", `SCD_DF20, df);
      chk("reply mb", exp_mb.size() ? exp_mb.pop_front() : 'x, mb);
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    // the x to 0 step at time zero is the falling edge that resets the design
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("reset airborne", 1'b1, air);
    chk("reset label", 32'h000000eb, lbl);
    rreg(`SCD_OFS_CTRL, {30'h0, `SCD_CTRL_RST});
    rreg(8'hfc, 32'h0);
    rnd(ident);
    wreg(`SCD_OFS_IDENT_LO, ident[31:0]);
    wreg(`SCD_OFS_IDENT_HI, {16'h0, ident[47:32]});
    foreach (tbl[i]) strap(tbl[i]);
    $display("test strap table done");
    // a config glitch shorter than the filter must leave configuration 0
    gnd <= 8'h0c;
    cyc(50);
    chk("glitch held config", 2'h0, cfg);
    gnd <= 8'h00;
    cyc(210);
    chk("glitch config", 2'h0, cfg);
    rnd(ads);
    wreg(`SCD_OFS_ADS_LO, ads[31:0]);
    wreg(`SCD_OFS_ADS_HI, {8'h0, ads[55:32]});
    ask(`SCD_BDS_05, 1, 1'b1, ads);
    cyc(60);
    ask(`SCD_BDS_05, 1, 1'b1, 56'h0);
    wreg(`SCD_OFS_CTRL, 32'h0);
    ask(`SCD_BDS_08, 1, 1'b0, 56'h0);
    ask(`SCD_BDS_05, 1, 1'b0, 56'h0);
    wreg(`SCD_OFS_CTRL, 32'h3);
    ask(8'h44, 1, 1'b0, 56'h0);
    $display("test replies done");
    cyc(4);
    chk("pending", 32'h0, exp_mb.size() + exp_rd.size());
    report_and_stop();
  end
endmodule
